//--- src/token_node_host_pointer_config.sv
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "token_node_map.svh"
module token_node_host_pointer_config
    import token_node_pkg::*;
#(
    parameter int              ADDR_W    = 8,
    parameter logic [3:0][27:0] RESP_CYC = {
        28'(`RESP_T3_TENTH_US * `CLK_KHZ / 10000),
        28'(`RESP_T2_TENTH_US * `CLK_KHZ / 10000),
        28'(`RESP_T1_TENTH_US * `CLK_KHZ / 10000),
        28'(`RESP_T0_TENTH_US * `CLK_KHZ / 10000)},
    parameter logic [3:0][27:0] IDLE_CYC = {
        28'(`IDLE_T3_US * `CLK_KHZ / 1000),
        28'(`IDLE_T2_US * `CLK_KHZ / 1000),
        28'(`IDLE_T1_US * `CLK_KHZ / 1000),
        28'(`IDLE_T0_US * `CLK_KHZ / 1000)},
    parameter logic [3:0][27:0] RECON_CYC = {
        28'(`RECON_T3_MS * `CLK_KHZ),
        28'(`RECON_T2_MS * `CLK_KHZ),
        28'(`RECON_T1_MS * `CLK_KHZ),
        28'(`RECON_T0_MS * `CLK_KHZ)}
) (
    // clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_b_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic [31:0]            prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // buffer ram port
    output logic [10:0]            ram_addr_o,
    output logic                   ram_rd_o,
    output logic                   ram_wr_o,
    output logic [7:0]             ram_wdata_o,
    input  wire logic [7:0]        ram_rdata_i,
    // line requests from the packet engine
    input  line_drive_type         drive_req_i,
    // line drivers, active high
    output logic                   transmit_drive_on_o,
    output logic                   line_drive_a_o,
    output logic                   line_drive_b_o,
    // controls to the rest of the node
    output logic [2:0]             indirect_sel_o,
    output logic                   soft_reset_o,
    output logic                   chain_enable_o,
    output logic                   backplane_o,
    output logic [1:0]             timeout_sel_o,
    output logic [1:0]             reconfig_timer_o,
    output logic [27:0]            response_timeout_cyc_o,
    output logic [27:0]            idle_timeout_cyc_o,
    output logic [27:0]            reconfig_timeout_cyc_o
);

    node_state_type state;
    node_state_type next_state;

    logic              setup;
    logic              access;
    logic [ADDR_W-1:0] ofs;
    logic              hit;
    logic              data_hit;
    logic              dir_bad;
    logic [31:0]       rd_mux;

    assign setup  = psel_i & ~penable_i;
    assign access = psel_i & penable_i;
    assign ofs    = paddr_i;

    assign data_hit = ofs == ADDR_W'(`OFS_DATA);
    // a data access against the prepared direction is refused
    assign dir_bad  = data_hit & (pwrite_i == state.dir);

    always_comb begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (ofs)
            ADDR_W'(`OFS_PTR_HIGH): begin
                rd_mux[`PH_DIR]              = state.dir;
                rd_mux[`PH_STEP]             = state.step;
                rd_mux[`PH_UPPER_HI:0]       = state.addr[10:8];
            end
            ADDR_W'(`OFS_PTR_LOW): begin
                rd_mux[7:0] = state.addr[7:0];
            end
            ADDR_W'(`OFS_SELECT): begin
                rd_mux[`SEL_HI:0] = state.sel;
            end
            ADDR_W'(`OFS_CONFIG): begin
                rd_mux[`CF_SOFT_RST]  = state.soft_rst;
                rd_mux[`CF_CHAIN]     = state.chain;
                rd_mux[`CF_TX_EN]     = state.tx_en;
                rd_mux[`CF_TO_HI]     = state.to_sel[1];
                rd_mux[`CF_TO_LO]     = state.to_sel[0];
                rd_mux[`CF_BACKPLANE] = state.backplane;
                rd_mux[`CF_SEL_MID]   = state.sel[1];
                rd_mux[`CF_SEL_LO]    = state.sel[0];
            end
            ADDR_W'(`OFS_RECON): begin
                rd_mux[`RC_HI:0] = state.recon;
            end
            ADDR_W'(`OFS_DATA): begin
                rd_mux[7:0] = ram_rdata_i;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // zero wait states: every access phase completes at once
    assign pready_o  = 1'b1;
    assign pslverr_o = access & (~hit | dir_bad);

    always_comb begin
        next_state        = state;
        next_state.ram_rd = 1'b0;
        next_state.ram_wr = 1'b0;

        // read data is caught in setup so that prdata is a flop
        if (setup) begin
            next_state.rdata = rd_mux;
        end

        if (access & pwrite_i & hit & ~dir_bad) begin
            unique case (ofs)
                ADDR_W'(`OFS_PTR_HIGH): begin
                    next_state.dir        = pwdata_i[`PH_DIR];
                    next_state.step       = pwdata_i[`PH_STEP];
                    next_state.addr[10:8] = pwdata_i[`PH_UPPER_HI:0];
                end
                ADDR_W'(`OFS_PTR_LOW): begin
                    next_state.addr[7:0] = pwdata_i[7:0];
                end
                ADDR_W'(`OFS_SELECT): begin
                    next_state.sel = pwdata_i[`SEL_HI:0];
                end
                ADDR_W'(`OFS_CONFIG): begin
                    next_state.soft_rst  = pwdata_i[`CF_SOFT_RST];
                    next_state.chain     = pwdata_i[`CF_CHAIN];
                    next_state.tx_en     = pwdata_i[`CF_TX_EN];
                    next_state.to_sel    = {pwdata_i[`CF_TO_HI],
                                            pwdata_i[`CF_TO_LO]};
                    next_state.backplane = pwdata_i[`CF_BACKPLANE];
                    // selector bit 2 lives only in the select register
                    next_state.sel[1:0]  = {pwdata_i[`CF_SEL_MID],
                                            pwdata_i[`CF_SEL_LO]};
                end
                ADDR_W'(`OFS_RECON): begin
                    next_state.recon = pwdata_i[`RC_HI:0];
                end
                default: begin
                    next_state.ram_wr    = 1'b1;
                    next_state.ram_wdata = pwdata_i[7:0];
                end
            endcase
        end

        if (access & ~pwrite_i & data_hit & ~dir_bad) begin
            next_state.ram_rd = 1'b1;
        end

        // pointer advances as one 11-bit value, wrapping at the top
        if (access & data_hit & ~dir_bad & state.step) begin
            next_state.addr = state.addr + 11'h001;
        end

        // line drivers pass engine requests only while enabled; drive b also passes while backplane is set
        next_state.drv_tx = state.tx_en & drive_req_i.tx;
        next_state.drv_a  = state.tx_en & drive_req_i.a;
        next_state.drv_b  = (state.tx_en | state.backplane)
                            & drive_req_i.b;

        // timeouts follow the select code; reconfig also by timer field
        next_state.resp_cyc  = RESP_CYC[state.to_sel];
        next_state.idle_cyc  = IDLE_CYC[state.to_sel];
        next_state.recon_cyc = RECON_CYC[state.to_sel]
                               << state.recon;
    end

    // asynchronous reset only; no soft reset reaches this state
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ram address is the live pointer; strobes follow the access
    assign ram_addr_o             = state.addr;
    assign ram_rd_o               = state.ram_rd;
    assign ram_wr_o               = state.ram_wr;
    assign ram_wdata_o            = state.ram_wdata;
    assign prdata_o               = state.rdata;
    assign transmit_drive_on_o    = state.drv_tx;
    assign line_drive_a_o         = state.drv_a;
    assign line_drive_b_o         = state.drv_b;
    assign indirect_sel_o         = state.sel;
    assign soft_reset_o           = state.soft_rst;
    assign chain_enable_o         = state.chain;
    assign backplane_o            = state.backplane;
    assign timeout_sel_o          = state.to_sel;
    assign reconfig_timer_o       = state.recon;
    assign response_timeout_cyc_o = state.resp_cyc;
    assign idle_timeout_cyc_o     = state.idle_cyc;
    assign reconfig_timeout_cyc_o = state.recon_cyc;

endmodule

//--- src/token_node_map.svh
`ifndef TOKEN_NODE_MAP_SVH
`define TOKEN_NODE_MAP_SVH

// register byte offsets
`define OFS_PTR_HIGH   8'h00
`define OFS_PTR_LOW    8'h04
`define OFS_SELECT     8'h08
`define OFS_CONFIG     8'h0c
`define OFS_RECON      8'h10
`define OFS_DATA       8'h14

// pointer-high fields
`define PH_DIR         7
`define PH_STEP        6
`define PH_UPPER_HI    2
// select register
`define SEL_HI         2
// configuration fields
`define CF_SOFT_RST    7
`define CF_CHAIN       6
`define CF_TX_EN       5
`define CF_TO_HI       4
`define CF_TO_LO       3
`define CF_BACKPLANE   2
`define CF_SEL_MID     1
`define CF_SEL_LO      0
// reconfiguration-timer field
`define RC_HI          1

// timing: clock rate and timeout figures per code
`define CLK_KHZ        10000
`define RESP_T0_TENTH_US 5966
`define RESP_T1_TENTH_US 2984
`define RESP_T2_TENTH_US 1492
`define RESP_T3_TENTH_US 374
`define IDLE_T0_US     656
`define IDLE_T1_US     328
`define IDLE_T2_US     164
`define IDLE_T3_US     41
`define RECON_T0_MS    840
`define RECON_T1_MS    840
`define RECON_T2_MS    840
`define RECON_T3_MS    420
`endif

//--- src/token_node_pkg.sv
package token_node_pkg;

    typedef struct packed {
        logic        dir;
        logic        step;
        logic [10:0] addr;
        logic [2:0]  sel;
        logic        soft_rst;
        logic        chain;
        logic        tx_en;
        logic [1:0]  to_sel;
        logic        backplane;
        logic [1:0]  recon;
        logic [31:0] rdata;
        logic        ram_rd;
        logic        ram_wr;
        logic [7:0]  ram_wdata;
        logic        drv_tx;
        logic        drv_a;
        logic        drv_b;
        logic [27:0] resp_cyc;
        logic [27:0] idle_cyc;
        logic [27:0] recon_cyc;
    } node_state_type;

    typedef struct packed {
        logic tx;
        logic a;
        logic b;
    } line_drive_type;

endpackage

//--- test/tb.sv
`timescale 1ns/10ps
module tb;
    import token_node_pkg::*;
    logic           core_clk_i = 1'b0;
    logic           rst_b_i = 1'b0;
    logic           psel_i = 1'b0;
    logic           penable_i = 1'b0;
    logic           pwrite_i = 1'b0;
    logic [7:0]     paddr_i = 8'h00;
    logic [31:0]    pwdata_i = 32'h0, prdata_o, rdq;
    logic           pready_o, pslverr_o, erq, ram_rd_o, ram_wr_o, soft_reset_o;
    logic           transmit_drive_on_o, line_drive_a_o, line_drive_b_o;
    logic           chain_enable_o, backplane_o;
    logic [10:0]    ram_addr_o;
    logic [7:0]     ram_wdata_o, ram_rdata_i;
    line_drive_type drive_req_i = '0;
    logic [2:0]     indirect_sel_o;
    logic [1:0]     timeout_sel_o, reconfig_timer_o;
    logic [27:0]    response_timeout_cyc_o, idle_timeout_cyc_o, reconfig_timeout_cyc_o;
    int             err_total = 0;
    int             checks_done = 0;

    always #50 core_clk_i = ~core_clk_i;

    token_node_host_pointer_config #(
        .RESP_CYC  ({28'h13, 28'h12, 28'h11, 28'h10}),
        .IDLE_CYC  ({28'h23, 28'h22, 28'h21, 28'h20}),
        .RECON_CYC ({28'h33, 28'h32, 28'h31, 28'h30})
    ) dut_u (
        .core_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .ram_addr_o, .ram_rd_o, .ram_wr_o, .ram_wdata_o, .ram_rdata_i,
        .drive_req_i, .transmit_drive_on_o, .line_drive_a_o, .line_drive_b_o, .indirect_sel_o,
        .soft_reset_o, .chain_enable_o, .backplane_o, .timeout_sel_o, .reconfig_timer_o,
        .response_timeout_cyc_o, .idle_timeout_cyc_o, .reconfig_timeout_cyc_o);

    token_node_ram_model ram_u (.core_clk_i, .addr_i(ram_addr_o), .wr_i(ram_wr_o),
        .wdata_i(ram_wdata_o), .rdata_o(ram_rdata_i));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic tick;
        @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask

    // answer is taken at the edge ending the access, sampled just before it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int   n;
        logic rdy;
        n = 0;
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do begin
            @(negedge core_clk_i);
            rdy = pready_o;
            rdq = prdata_o;
            erq = pslverr_o;
            n++;
            @(posedge core_clk_i);
        end while (rdy !== 1'b1 && n < 20);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(negedge core_clk_i);
        if (rdy !== 1'b1) begin
            err_total++;
            report_and_stop;
        end
    endtask

    task automatic t_reset;
        tick;
        cmp({ram_addr_o, indirect_sel_o, soft_reset_o, chain_enable_o, backplane_o,
             transmit_drive_on_o, line_drive_a_o, line_drive_b_o}, 32'h0);
        cmp({response_timeout_cyc_o[23:0], idle_timeout_cyc_o[7:0]}, 32'h0000_1020);
        apb(1'b0, 8'h0c, 32'h0);
        cmp(rdq, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_pointer;
        apb(1'b1, 8'h00, 32'h47);
        apb(1'b1, 8'h04, 32'hff);
        cmp(ram_addr_o, 32'h7ff);
        apb(1'b1, 8'h14, 32'ha5);
        cmp({ram_wr_o, ram_wdata_o, ram_addr_o}, {1'b1, 8'ha5, 11'h0});
        apb(1'b0, 8'h14, 32'h0);
        cmp({erq, ram_rd_o}, 32'h2);
        apb(1'b1, 8'h00, 32'hc7);
        apb(1'b1, 8'h04, 32'hff);
        apb(1'b0, 8'h14, 32'h0);
        cmp({erq, ram_rd_o, rdq[7:0], ram_addr_o}, {2'b01, 8'ha5, 11'h0});
        apb(1'b1, 8'h00, 32'h83);
        apb(1'b1, 8'h04, 32'h10);
        apb(1'b0, 8'h14, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        cmp(ram_addr_o, 32'h310);
        apb(1'b0, 8'h00, 32'h0);
        cmp(rdq, 32'h83);
        apb(1'b0, 8'h18, 32'h0);
        cmp({erq, rdq[30:0]}, 32'h8000_0000);
        $display("test pointer done");
    endtask

    task automatic t_select;
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, 8'h08, 32'(c));
            cmp(indirect_sel_o, 32'(c));
        end
        apb(1'b1, 8'h0c, 32'h02);
        apb(1'b0, 8'h08, 32'h0);
        cmp({indirect_sel_o, rdq[7:0]}, 32'h606);
        $display("test select done");
    endtask

    task automatic t_config;
        apb(1'b1, 8'h0c, 32'hc4);
        cmp({soft_reset_o, chain_enable_o, backplane_o, transmit_drive_on_o}, 32'he);
        apb(1'b1, 8'h0c, 32'h44);
        cmp({soft_reset_o, chain_enable_o}, 32'h1);
        apb(1'b1, 8'h10, 32'h2);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 8'h0c, 32'(c) << 3);
            tick;
            cmp({reconfig_timer_o, timeout_sel_o}, 32'(8 + c));
            cmp({response_timeout_cyc_o[23:0], idle_timeout_cyc_o[7:0]}, 32'h1020 + 32'h101 * c);
            cmp(reconfig_timeout_cyc_o, (32'h30 + c) << 2);
        end
        $display("test config done");
    endtask

    task automatic t_drive;
        apb(1'b1, 8'h0c, 32'h04);
        @(posedge core_clk_i);
        drive_req_i <= 3'b111;
        tick;
        cmp({transmit_drive_on_o, line_drive_a_o, line_drive_b_o}, 32'h1);
        apb(1'b1, 8'h0c, 32'h00);
        tick;
        cmp({transmit_drive_on_o, line_drive_a_o, line_drive_b_o}, 32'h0);
        apb(1'b1, 8'h0c, 32'h20);
        tick;
        cmp({transmit_drive_on_o, line_drive_a_o, line_drive_b_o}, 32'h7);
        $display("test drive done");
    endtask

    initial begin
        repeat (3) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        t_reset;
        t_pointer;
        t_select;
        t_config;
        t_drive;
        report_and_stop;
    end
endmodule

//--- test/token_node_asserts.sv
`timescale 1ns/10ps
module token_node_asserts #(
    parameter int ADDR_W = 8
) (
    // clock, reset and apb
    input wire logic              core_clk_i,
    input wire logic              rst_b_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0]       pwdata_i,
    input wire logic              pslverr_o,
    // ram port and controls
    input wire logic [10:0]       ram_addr_o,
    input wire logic              ram_rd_o,
    input wire logic              ram_wr_o,
    input wire logic [7:0]        ram_wdata_o,
    input wire logic              soft_reset_o
);
    wire logic acc = psel_i & penable_i;
    wire logic wacc = acc & pwrite_i;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    chk_high_ptr: assert property (wacc && paddr_i == 8'h00
        |=> ram_addr_o[10:8] == $past(pwdata_i[2:0])) else $error("upper pointer wrong");
    chk_low_ptr: assert property (wacc && paddr_i == 8'h04
        |=> ram_addr_o[7:0] == $past(pwdata_i[7:0])) else $error("lower pointer wrong");
    chk_wr_cause: assert property (ram_wr_o |-> $past(wacc && paddr_i == 8'h14 && !pslverr_o)
        && ram_wdata_o == $past(pwdata_i[7:0])) else $error("bad ram write");
    chk_rd_cause: assert property (ram_rd_o
        |-> $past(acc && !pwrite_i && paddr_i == 8'h14 && !pslverr_o)) else $error("bad ram read");
    chk_ptr_hold: assert property (!$past(wacc) && !ram_rd_o && !ram_wr_o
        |-> $stable(ram_addr_o)) else $error("pointer moved");
    chk_ptr_step: assert property (ram_rd_o || ram_wr_o
        |-> 11'(ram_addr_o - $past(ram_addr_o)) <= 11'h1) else $error("pointer jump");
    chk_unmapped_err: assert property (acc && (paddr_i > 8'h14 || paddr_i[1:0] != 2'h0)
        |-> pslverr_o) else $error("unmapped not refused");
    chk_soft_hold: assert property (soft_reset_o && !(wacc && paddr_i == 8'h0c)
        |=> soft_reset_o) else $error("soft reset dropped");
    cover property (ram_wr_o);
    cover property (ram_rd_o);
    cover property (acc && pslverr_o);
endmodule
bind token_node_host_pointer_config token_node_asserts #(.ADDR_W(ADDR_W)) chk_u (
    .core_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pslverr_o,
    .ram_addr_o, .ram_rd_o, .ram_wr_o, .ram_wdata_o, .soft_reset_o);

//--- test/token_node_ram_model.sv
`timescale 1ns/10ps
module token_node_ram_model (
    // block side of the buffer ram
    input  wire logic        core_clk_i,
    input  wire logic [10:0] addr_i,
    input  wire logic        wr_i,
    input  wire logic [7:0]  wdata_i,
    output logic [7:0]       rdata_o
);
    logic [7:0]  mem [2048];
    logic [10:0] addr_q;
    // strobe trails the access, so the pointer may have stepped already
    always_ff @(posedge core_clk_i) begin
        addr_q <= addr_i;
        if (wr_i) begin
            mem[addr_q] <= wdata_i;
        end
    end
    assign rdata_o = mem[addr_i];
endmodule
